// ==== common/psp_defs.svh ====
`ifndef PSP_DEFS_SVH
`define PSP_DEFS_SVH

// Port mode encodings
`define PSP_MODE_LEGACY   2'h0
`define PSP_MODE_ADDR     2'h1
// Increment mode for buffered operation
`define PSP_INCM_BUFFERED 2'h3
// Interrupt mode encodings
`define PSP_IRQM_NONE     2'h0
`define PSP_IRQM_EVERY    2'h1
`define PSP_IRQM_LAST     2'h3
// Last buffer byte index
`define PSP_LAST_BYTE     2'h3
// Reset values of the flag groups
`define PSP_OUT_EMPTY_RST 4'hF
`define PSP_IN_FULL_RST   4'h0
`define PSP_DATA_RST      8'h00

`endif

// ==== common/psp_pkg.sv ====
package psp_pkg;
    typedef logic [7:0] psp_byte_type;
    typedef logic [1:0] psp_idx_type;
    typedef enum logic [1:0] {PSP_ACC_IDLE, PSP_ACC_READ, PSP_ACC_WRITE}
        psp_acc_type;
endpackage : psp_pkg

// ==== common/psp_strobe_if.sv ====
interface psp_strobe_if;
    logic rd_start;
    logic rd_end;
    logic wr_end;
    logic rd_active;
    modport src (output rd_start, output rd_end, output wr_end,
                 output rd_active);
    modport dst (input rd_start, input rd_end, input wr_end,
                 input rd_active);
endinterface : psp_strobe_if

// ==== src/psp_sync.sv ====
module psp_sync
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_r      <= 1'b0;
            s2_r      <= 1'b0;
            s3_r      <= 1'b0;
            level_out <= 1'b0;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Accept a change only when two late stages agree
            if (s2_r == s3_r)
                level_out <= s3_r;
        end
    end
endmodule : psp_sync

// ==== src/psp_strobe.sv ====
module psp_strobe
(
    input  wire logic  core_clk,
    input  wire logic  rst,
    input  wire logic  select_in_one,
    input  wire logic  read_strobe,
    input  wire logic  write_strobe,
    input  wire logic  cs_active_high,
    input  wire logic  rd_active_high,
    input  wire logic  wr_active_high,
    psp_strobe_if.src  ev
);
    logic cs_s;
    logic rd_s;
    logic wr_s;
    logic rd_act_r;
    logic wr_act_r;

    psp_sync u_cs (.core_clk(core_clk), .rst(rst), .pin_in(select_in_one),
                   .level_out(cs_s));
    psp_sync u_rd (.core_clk(core_clk), .rst(rst), .pin_in(read_strobe),
                   .level_out(rd_s));
    psp_sync u_wr (.core_clk(core_clk), .rst(rst), .pin_in(write_strobe),
                   .level_out(wr_s));

    wire cs_on  = cs_s ~^ cs_active_high;
    wire rd_on  = cs_on & (rd_s ~^ rd_active_high);
    wire wr_on  = cs_on & (wr_s ~^ wr_active_high);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_act_r <= 1'b0;
            wr_act_r <= 1'b0;
        end
        else
        begin
            rd_act_r <= rd_on;
            wr_act_r <= wr_on;
        end
    end

    assign ev.rd_start  = rd_on & ~rd_act_r;
    // read ends when select or read strobe goes inactive
    assign ev.rd_end    = ~rd_on & rd_act_r;
    assign ev.wr_end    = ~wr_on & wr_act_r;
    assign ev.rd_active = rd_on;
endmodule : psp_strobe

// ==== src/parallel_slave_port.sv ====
`include "psp_defs.svh"

// Summary of operation
// - Slave operation only when module on and port mode is 00 or 01.
// - Legacy mode is port mode 00 with increment mode other than 11.
// - Only select line one is used; select line two is ignored.
// - Select, read and write strobe polarities are selectable.
// - Legacy write captures data bus into input byte 0.
// - Each host write end sets interrupt and input-full flags.
// - Legacy read drives output byte 0, then sets output-empty.
// - Software load makes data readable but leaves empty flag set.
// - Select or read going inactive releases pins, raises interrupt.
// - Buffered mode uses increment mode 11 with four-byte queues.
// - Buffer bytes 0..3 are lo/hi of register one, lo/hi of two.
// - Sequential pointers step bytes 0 toward 3 per strobe.
// - Output byte empty flag clears on load, sets once driven.
// - Reading an already empty output byte sets sticky underflow.
// - Aggregate output-empty when all four byte empty flags set.
// - Input byte full set by host write, cleared by software read.
// - Writing a full input byte sets sticky overflow, data lost.
// - Aggregate input-full when all four byte full flags set; legacy mode uses byte 0 alone.
// - Interrupt mode 01 raises interrupt on every strobe.
// - Interrupt mode 11 raises interrupt only for byte 3 access, except in legacy mode.
// - Port mode 01 selects addressable mode with two address inputs.
// - Addresses 00, 01, 10 select bytes 0, 1, 2.
// - Address 11 selects byte 3; interrupts in mode 11 there.
// - Addressable write to full byte sets overflow and discards.
module parallel_slave_port
#(
    parameter int NUM_BYTES = 4
)
(
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 module_on,
    input  wire logic [1:0]           port_mode_reg,
    input  wire logic [1:0]           increment_mode_sel,
    input  wire logic [1:0]           irq_mode_sel,
    input  wire logic                 cs_active_high,
    input  wire logic                 rd_active_high,
    input  wire logic                 wr_active_high,
    input  wire logic                 select_in_one,
    input  wire logic                 select_out_two,
    input  wire logic                 read_strobe,
    input  wire logic                 write_strobe,
    input  wire logic [1:0]           addr_inputs,
    input  wire psp_pkg::psp_byte_type data_bus_in,
    output psp_pkg::psp_byte_type     data_bus_out,
    output logic                      data_bus_oe,
    input  wire logic                 sw_out_load,
    input  wire psp_pkg::psp_idx_type sw_out_idx,
    input  wire psp_pkg::psp_byte_type sw_out_data,
    input  wire logic                 sw_in_read,
    input  wire psp_pkg::psp_idx_type sw_in_idx,
    input  wire logic                 sw_clr_overflow,
    input  wire logic                 sw_clr_underflow,
    output logic [15:0]               in_buf_lo,
    output logic [15:0]               in_buf_hi,
    output logic [3:0]                in_byte_full,
    output logic [3:0]                out_byte_empty,
    output logic                      in_all_full,
    output logic                      out_all_empty,
    output logic                      in_overflow,
    output logic                      out_underflow,
    output logic                      port_irq_flag
);
    import psp_pkg::*;

    // Flag words and byte indices are built for a four-byte queue
    if (NUM_BYTES != 4)
    begin : g_depth_check
        $error("only a four-byte queue is supported");
    end

    psp_strobe_if ev ();

    psp_byte_type out_mem_r [NUM_BYTES];
    psp_byte_type in_mem_r  [NUM_BYTES];
    psp_idx_type  rd_ptr_r;
    psp_idx_type  wr_ptr_r;
    psp_idx_type  rd_idx_r;
    psp_acc_type  acc_r;
    psp_acc_type  acc_nxt;
    logic         on_r;

    // select line two plays no part in slave modes
    wire unused_cs2 = select_out_two;

    psp_strobe u_strobe (
        .core_clk       (core_clk),
        .rst            (rst),
        .select_in_one  (select_in_one),
        .read_strobe    (read_strobe),
        .write_strobe   (write_strobe),
        .cs_active_high (cs_active_high),
        .rd_active_high (rd_active_high),
        .wr_active_high (wr_active_high),
        .ev             (ev.src)
    );

    wire slave_mode = (port_mode_reg == `PSP_MODE_LEGACY) |
                      (port_mode_reg == `PSP_MODE_ADDR);
    wire slave_on   = module_on & slave_mode;
    wire addr_mode  = port_mode_reg == `PSP_MODE_ADDR;
    // legacy (single byte) unless increment mode 11
    // increment mode 11 gives the four-byte queues
    wire buf_mode   = (port_mode_reg == `PSP_MODE_LEGACY) &
                      (increment_mode_sel == `PSP_INCM_BUFFERED);
    wire seq_mode   = ~addr_mode & buf_mode;
    // Re-enabling the port restarts pointers and status
    wire enable_rise = module_on & ~on_r;

    // legacy mode always uses byte 0
    wire psp_idx_type rd_sel = addr_mode ? addr_inputs :
                               (seq_mode ? rd_ptr_r : 2'h0);
    wire psp_idx_type wr_sel = addr_mode ? addr_inputs :
                               (seq_mode ? wr_ptr_r : 2'h0);

    wire host_rd = slave_on & ev.rd_start;
    wire host_wr = slave_on & ev.wr_end;
    // write to full byte is dropped
    wire wr_ovf  = host_wr & in_byte_full[wr_sel];
    wire rd_unf  = host_rd & out_byte_empty[rd_sel];

    // every strobe; only byte 3 in mode 11
    wire irq_every = (irq_mode_sel == `PSP_IRQM_EVERY) &
                     ((slave_on & ev.rd_end) | host_wr);
    wire irq_last  = (irq_mode_sel == `PSP_IRQM_LAST) &
                     (((slave_on & ev.rd_end) &
                       (rd_idx_r == `PSP_LAST_BYTE)) |
                      (host_wr & (wr_sel == `PSP_LAST_BYTE)));
    // neither addressable nor buffered is the one-byte port
    wire legacy_mode = ~addr_mode & ~buf_mode;
    // legacy write end; legacy read end
    wire irq_legacy = legacy_mode &
                      ((slave_on & ev.rd_end) | host_wr);
    // the single legacy byte stands for the whole input queue
    // otherwise all four bytes must be full
    wire in_full_agg = legacy_mode ? in_byte_full[0] : &in_byte_full;
    wire irq_evt = irq_every | irq_last | irq_legacy;

    // Access tracker: idle, read in progress or write just ended
    always_comb
    begin
        acc_nxt = acc_r;
        if (!slave_on)
            acc_nxt = PSP_ACC_IDLE;
        else if (host_rd)
            acc_nxt = PSP_ACC_READ;
        else if (host_wr)
            acc_nxt = PSP_ACC_WRITE;
        else if (ev.rd_end | (acc_r == PSP_ACC_WRITE))
            acc_nxt = PSP_ACC_IDLE;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            on_r     <= 1'b0;
            acc_r    <= PSP_ACC_IDLE;
            rd_ptr_r <= 2'h0;
            wr_ptr_r <= 2'h0;
            rd_idx_r <= 2'h0;
        end
        else
        begin
            on_r  <= module_on;
            acc_r <= acc_nxt;
            // pointers restart on enable and wrap naturally
            if (enable_rise)
            begin
                rd_ptr_r <= 2'h0;
                wr_ptr_r <= 2'h0;
            end
            else
            begin
                if (host_rd & seq_mode)
                    rd_ptr_r <= rd_ptr_r + 2'h1;
                if (host_wr & seq_mode)
                    wr_ptr_r <= wr_ptr_r + 2'h1;
            end
            if (host_rd)
                rd_idx_r <= rd_sel;
        end
    end

    // drive selected byte while read strobe active
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            data_bus_out <= `PSP_DATA_RST;
            data_bus_oe  <= 1'b0;
        end
        else
        begin
            data_bus_oe <= slave_on & ev.rd_active;
            if (host_rd)
                data_bus_out <= out_mem_r[rd_sel];
            // later software load is seen at once
            else if (sw_out_load & (sw_out_idx == rd_idx_r))
                data_bus_out <= sw_out_data;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NUM_BYTES; i++)
            begin
                out_mem_r[i] <= `PSP_DATA_RST;
                in_mem_r[i]  <= `PSP_DATA_RST;
            end
        end
        else
        begin
            if (sw_out_load)
                out_mem_r[sw_out_idx] <= sw_out_data;
            // capture data bus at write end
            if (host_wr & ~wr_ovf)
                in_mem_r[wr_sel] <= data_bus_in;
        end
    end

    // Flag updates: hardware set wins over software clear
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            out_byte_empty <= `PSP_OUT_EMPTY_RST;
            in_byte_full   <= `PSP_IN_FULL_RST;
            in_overflow    <= 1'b0;
            out_underflow  <= 1'b0;
            port_irq_flag  <= 1'b0;
        end
        else if (enable_rise)
        begin
            out_byte_empty <= `PSP_OUT_EMPTY_RST;
            in_byte_full   <= `PSP_IN_FULL_RST;
            in_overflow    <= 1'b0;
            out_underflow  <= 1'b0;
            port_irq_flag  <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NUM_BYTES; i++)
            begin
                // empty clears on load, sets when driven
                // in legacy mode a load leaves empty set
                if (host_rd & (rd_sel == 2'(i)))
                    out_byte_empty[i] <= 1'b1;
                else if (sw_out_load & (sw_out_idx == 2'(i)) &
                         (addr_mode | buf_mode))
                    out_byte_empty[i] <= 1'b0;
                // full set by host write, cleared by read
                if (host_wr & (wr_sel == 2'(i)))
                    in_byte_full[i] <= 1'b1;
                else if (sw_in_read & (sw_in_idx == 2'(i)))
                    in_byte_full[i] <= 1'b0;
            end
            if (wr_ovf)
                in_overflow <= 1'b1;
            else if (sw_clr_overflow)
                in_overflow <= 1'b0;
            if (rd_unf)
                out_underflow <= 1'b1;
            else if (sw_clr_underflow)
                out_underflow <= 1'b0;
            port_irq_flag <= irq_evt;
        end
    end

    // aggregate flags, one cycle behind byte flags
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            in_all_full   <= 1'b0;
            out_all_empty <= 1'b1;
            in_buf_lo     <= 16'h0000;
            in_buf_hi     <= 16'h0000;
        end
        else
        begin
            in_all_full   <= in_full_agg;
            out_all_empty <= &out_byte_empty;
            in_buf_lo     <= {in_mem_r[1], in_mem_r[0]};
            in_buf_hi     <= {in_mem_r[3], in_mem_r[2]};
        end
    end
endmodule : parallel_slave_port

// ==== bench/psp_props.sv ====
module psp_props
(
    input wire logic                  core_clk,
    input wire logic                  rst,
    input wire logic                  module_on,
    input wire logic [1:0]            port_mode_reg,
    input wire logic [1:0]            increment_mode_sel,
    input wire logic [1:0]            irq_mode_sel,
    input wire psp_pkg::psp_byte_type data_bus_out,
    input wire logic                  data_bus_oe,
    input wire logic                  sw_out_load,
    input wire logic                  sw_in_read,
    input wire logic                  sw_clr_overflow,
    input wire logic                  sw_clr_underflow,
    input wire logic [3:0]            in_byte_full,
    input wire logic [3:0]            out_byte_empty,
    input wire logic                  in_all_full,
    input wire logic                  out_all_empty,
    input wire logic                  in_overflow,
    input wire logic                  out_underflow,
    input wire logic                  port_irq_flag
);
    import psp_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire legacy_m = port_mode_reg == 2'h0 && increment_mode_sel != 2'h3;

    agg_out_a: assert property (
        out_all_empty == $past(&out_byte_empty))
        else $error("aggregate empty does not follow byte flags");
    agg_in_a: assert property (
        in_all_full == $past(legacy_m ? in_byte_full[0] : &in_byte_full))
        else $error("aggregate full does not follow byte flags");
    uflow_sticky_a: assert property (
        out_underflow && !sw_clr_underflow && module_on &&
        !$rose(module_on) |=> out_underflow)
        else $error("underflow flag dropped without clear");
    oflow_sticky_a: assert property (
        in_overflow && !sw_clr_overflow && module_on &&
        !$rose(module_on) |=> in_overflow)
        else $error("overflow flag dropped without clear");
    drive_mode_a: assert property (
        data_bus_oe |-> module_on && !port_mode_reg[1])
        else $error("data bus driven outside slave modes");
    full_clear_a: assert property (
        |($past(in_byte_full) & ~in_byte_full) |-> $past(sw_in_read) ||
        ($past(module_on) && !$past(module_on, 2)))
        else $error("input full flag cleared without software read");
    empty_clear_a: assert property (
        |($past(out_byte_empty) & ~out_byte_empty) |-> $past(sw_out_load))
        else $error("output empty flag cleared without load");
    release_irq_a: assert property (
        $fell(data_bus_oe) && irq_mode_sel == 2'h1 |-> port_irq_flag)
        else $error("no interrupt when bus released");
    irq_pulse_a: assert property (
        port_irq_flag |=> !port_irq_flag [*2])
        else $error("interrupt pulse too long");
    read_hold_a: assert property (
        data_bus_oe && $past(data_bus_oe) && !$past(sw_out_load) |->
        $stable(data_bus_out))
        else $error("read data changed while driven");

    full_c: cover property (in_all_full);
    uflow_c: cover property (out_underflow);
    oflow_c: cover property (in_overflow);
    legacy_c: cover property (legacy_m && port_irq_flag);
endmodule : psp_props

// ==== bench/psp_host.sv ====
module psp_host
(
    input  wire logic                  core_clk,
    input  wire logic [2:0]            pol,
    input  wire psp_pkg::psp_byte_type rd_data,
    output logic                       cs,
    output logic                       rd,
    output logic                       wr,
    output logic [1:0]                 addr,
    output psp_pkg::psp_byte_type      dout
);
    import psp_pkg::*;
    initial
    begin
        {cs, rd, wr} = 3'h0;
        addr = 2'h0;
        dout = 8'h00;
    end
    task idle;
        {cs, rd, wr} = ~pol;
    endtask : idle
    // Lines not held by the rules are inverted so stale values never match
    task access(input logic w, input logic [1:0] a, input psp_byte_type d,
                input int n, output psp_byte_type q);
        @(negedge core_clk);
        addr = a;
        dout = d;
        cs = pol[2];
        repeat (2) @(negedge core_clk);
        if (w)
            wr = pol[0];
        else
            rd = pol[1];
        repeat (n) @(negedge core_clk);
        q = rd_data;
        {rd, wr} = ~pol[1:0];
        repeat (n) @(negedge core_clk);
        cs = ~pol[2];
        addr = ~a;
        dout = ~d;
        repeat (n) @(negedge core_clk);
    endtask : access
endmodule : psp_host

// ==== bench/parallel_slave_port_tb_top.sv ====
`define CHK(n, e, a) \
    if ((a) !== (e)) \
    begin \
        $display("ERROR %s exp %0h got %0h", n, e, a); \
        n_mismatch++; \
    end \
    compares++;

module parallel_slave_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import psp_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic module_on = 1'b1;
    logic [1:0] port_mode_reg = 2'h0;
    logic [1:0] increment_mode_sel = 2'h3;
    logic [1:0] irq_mode_sel = 2'h1;
    logic [2:0] pol = 3'h7;
    logic select_in_one, read_strobe, write_strobe;
    logic select_out_two = 1'b0;
    logic [1:0] addr_inputs;
    psp_byte_type data_bus_in, data_bus_out, sw_out_data = 8'h00;
    psp_byte_type q, x, d[4], e[4];
    psp_idx_type sw_out_idx = 2'h0, sw_in_idx = 2'h0;
    logic sw_out_load = 1'b0, sw_in_read = 1'b0;
    logic sw_clr_overflow = 1'b0, sw_clr_underflow = 1'b0;
    logic data_bus_oe, in_all_full, out_all_empty;
    logic in_overflow, out_underflow, port_irq_flag;
    logic [15:0] in_buf_lo, in_buf_hi;
    logic [3:0] in_byte_full, out_byte_empty;
    int n_mismatch = 0, compares = 0, n_irq = 0, base = 0;
    int seed = 32'hc297d20b;

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
        if (port_irq_flag === 1'b1)
            n_irq++;

    parallel_slave_port parallel_slave_port_i (.core_clk, .rst, .module_on,
        .port_mode_reg, .increment_mode_sel, .irq_mode_sel,
        .cs_active_high(pol[2]), .rd_active_high(pol[1]),
        .wr_active_high(pol[0]), .select_in_one, .select_out_two,
        .read_strobe, .write_strobe, .addr_inputs, .data_bus_in,
        .data_bus_out, .data_bus_oe, .sw_out_load, .sw_out_idx,
        .sw_out_data, .sw_in_read, .sw_in_idx, .sw_clr_overflow,
        .sw_clr_underflow, .in_buf_lo, .in_buf_hi, .in_byte_full,
        .out_byte_empty, .in_all_full, .out_all_empty, .in_overflow,
        .out_underflow, .port_irq_flag);
    psp_host psp_host_i (.core_clk, .pol, .rd_data(data_bus_out),
        .cs(select_in_one), .rd(read_strobe), .wr(write_strobe),
        .addr(addr_inputs), .dout(data_bus_in));

    function logic [15:0] pack(input psp_byte_type lo, input psp_byte_type hi);
        return {hi, lo};
    endfunction : pack
    task xf(input logic w, input psp_idx_type a, input psp_byte_type v);
        // select line two toggles freely and must change nothing
        select_out_two = 1'($random(seed));
        psp_host_i.access(w, a, v, 6 + ($random(seed) & 32'h3), q);
    endtask : xf
    // Kinds: 0 load output byte, 1 read input byte, 2 and 3 clear flags
    task sw_op(input int k, input psp_idx_type i, input psp_byte_type v);
        @(negedge core_clk);
        sw_out_idx = i;
        sw_in_idx = i;
        sw_out_data = v;
        {sw_clr_underflow, sw_clr_overflow, sw_in_read, sw_out_load} = 4'h1 << k;
        @(negedge core_clk);
        {sw_clr_underflow, sw_clr_overflow, sw_in_read, sw_out_load} = 4'h0;
        repeat (2) @(negedge core_clk);
    endtask : sw_op
    task complete_run;
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    initial
    begin
        #100000;
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        `CHK("empty", 4'hF, out_byte_empty)
        `CHK("all_empty", 1'b1, out_all_empty)
        `CHK("full", 4'h0, in_byte_full)
        for (int i = 0; i < 4; i++)
        begin
            d[i] = $random(seed);
            xf(1'b1, 2'h0, d[i]);
        end
        `CHK("in_lo", pack(d[0], d[1]), in_buf_lo)
        `CHK("in_hi", pack(d[2], d[3]), in_buf_hi)
        `CHK("all_full", 1'b1, in_all_full)
        `CHK("irq", 4, n_irq)
        xf(1'b1, 2'h0, ~d[0]);
        `CHK("ovf", 1'b1, in_overflow)
        `CHK("in_b0", d[0], in_buf_lo[7:0])
        for (int i = 0; i < 4; i++)
            sw_op(1, i, 8'h00);
        sw_op(2, 2'h0, 8'h00);
        `CHK("full", 4'h0, in_byte_full)
        `CHK("ovf", 1'b0, in_overflow)
        for (int i = 0; i < 4; i++)
        begin
            e[i] = $random(seed);
            sw_op(0, i, e[i]);
        end
        `CHK("empty", 4'h0, out_byte_empty)
        for (int i = 0; i < 4; i++)
        begin
            xf(1'b0, 2'h0, 8'h00);
            `CHK("rd", e[i], q)
        end
        `CHK("all_empty", 1'b1, out_all_empty)
        xf(1'b0, 2'h0, 8'h00);
        `CHK("ufl", 1'b1, out_underflow)
        `CHK("rd_wrap", e[0], q)
        sw_op(3, 2'h0, 8'h00);
        `CHK("ufl", 1'b0, out_underflow)
        `CHK("irq", 10, n_irq)
        port_mode_reg = 2'h2;
        pol = 3'h0;
        psp_host_i.idle();
        repeat (8) @(negedge core_clk);
        port_mode_reg = 2'h1;
        irq_mode_sel = 2'h3;
        base = n_irq;
        x = $random(seed);
        xf(1'b1, 2'h2, x);
        `CHK("in_b2", x, in_buf_hi[7:0])
        `CHK("full", 4'h4, in_byte_full)
        `CHK("irq", base, n_irq)
        xf(1'b1, 2'h3, ~x);
        `CHK("in_b3", ~x, in_buf_hi[15:8])
        `CHK("irq", base + 1, n_irq)
        xf(1'b1, 2'h2, ~x);
        `CHK("ovf", 1'b1, in_overflow)
        `CHK("in_b2", x, in_buf_hi[7:0])
        sw_op(0, 2'h1, ~x);
        xf(1'b0, 2'h1, 8'h00);
        `CHK("rd", ~x, q)
        `CHK("irq", base + 1, n_irq)
        port_mode_reg = 2'h2;
        sw_op(1, 2'h2, 8'h00);
        xf(1'b1, 2'h2, x);
        `CHK("full", 4'h8, in_byte_full)
        module_on = 1'b0;
        repeat (3) @(negedge core_clk);
        module_on = 1'b1;
        repeat (3) @(negedge core_clk);
        `CHK("full", 4'h0, in_byte_full)
        `CHK("ovf", 1'b0, in_overflow)
        increment_mode_sel = 2'h0;
        port_mode_reg = 2'h0;
        irq_mode_sel = 2'h0;
        base = n_irq;
        x = $random(seed);
        xf(1'b1, 2'h3, x);
        `CHK("in_b0", x, in_buf_lo[7:0])
        `CHK("all_full", 1'b1, in_all_full)
        `CHK("irq", base + 1, n_irq)
        sw_op(0, 2'h0, ~x);
        `CHK("empty", 4'hF, out_byte_empty)
        xf(1'b0, 2'h2, 8'h00);
        `CHK("rd", ~x, q)
        `CHK("all_empty", 1'b1, out_all_empty)
        `CHK("oe", 1'b0, data_bus_oe)
        `CHK("irq", base + 2, n_irq)
        sw_op(1, 2'h0, 8'h00);
        increment_mode_sel = 2'h3;
        xf(1'b1, 2'h2, ~x);
        `CHK("full", 4'h1, in_byte_full)
        `CHK("in_b0", ~x, in_buf_lo[7:0])
        complete_run();
    end
endmodule : parallel_slave_port_tb_top

bind parallel_slave_port psp_props psp_props_i (.core_clk, .rst, .module_on,
    .port_mode_reg, .increment_mode_sel, .irq_mode_sel, .data_bus_out,
    .data_bus_oe, .sw_out_load, .sw_in_read, .sw_clr_overflow,
    .sw_clr_underflow, .in_byte_full, .out_byte_empty, .in_all_full,
    .out_all_empty, .in_overflow, .out_underflow, .port_irq_flag);
